// *** src/dmtc_top.sv ***
// direct mode transition sequencer with register port and interrupt
// assumes sleep_exec is a one-cycle pulse from the cpu and inputs are synchronous to clk
//
// Chosen here: the strobed register port and the register addresses.
module dmtc_top #(
   parameter logic [15:0] WAIT_LONG_STATES = 16'h2_000,
   parameter logic [15:0] TW_CLKS          = 16'h0_004
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [7:0]  rd_data,
   input  wire logic        sleep_exec,
   input  wire logic        cpu_int_mask,
   input  wire logic        wake_req,
   output logic      [1:0]  cpu_clk_sel,
   output logic             cpu_hold,
   output logic             exc_start,
   output logic             xfer_done,
   output logic             lowpower_on,
   output logic             irq
);

   // =====================================================
   // helpers
   // oscillator cycles per cpu state in a given mode
   function automatic logic [15:0] state_period(input dmtc_pkg::dmtc_mode_t m);
      logic [31:0] sub;
      sub = 32'(dmtc_pkg::SUB_TW_MULT) * 32'(TW_CLKS);
      case (m)
         dmtc_pkg::DMTC_HS:  state_period = dmtc_pkg::HS_DIV;
         dmtc_pkg::DMTC_MS:  state_period = dmtc_pkg::MS_DIV;
         dmtc_pkg::DMTC_SUB: state_period = sub[15:0];
         default:            state_period = dmtc_pkg::MS_DIV;
      endcase
   endfunction

   // wait states picked by the three-bit selector
   function automatic logic [15:0] wait_states(input logic [2:0] sel);
      case (sel)
         3'h0:    wait_states = WAIT_LONG_STATES;
         3'h1:    wait_states = dmtc_pkg::WAIT_SEL1;
         3'h2:    wait_states = dmtc_pkg::WAIT_SEL2;
         3'h3:    wait_states = dmtc_pkg::WAIT_SEL3;
         3'h4:    wait_states = dmtc_pkg::WAIT_SEL4;
         3'h5:    wait_states = dmtc_pkg::WAIT_SEL5;
         3'h6:    wait_states = dmtc_pkg::WAIT_SEL6;
         default: wait_states = dmtc_pkg::WAIT_SEL7;
      endcase
   endfunction

   // =====================================================
   // registers
   dmtc_pkg::dmtc_ctl_one_t ctl_one_ff,  nxt_ctl_one;
   dmtc_pkg::dmtc_ctl_two_t ctl_two_ff,  nxt_ctl_two;
   logic                    twcs_ff,     nxt_twcs;
   dmtc_pkg::dmtc_evt_t     int_stat_ff, nxt_int_stat;
   dmtc_pkg::dmtc_evt_t     int_mask_ff, nxt_int_mask;
   logic [7:0]              rd_data_ff,  nxt_rd_data;

   // sequencer state
   dmtc_pkg::dmtc_state_t   state_ff,    nxt_state;
   dmtc_pkg::dmtc_mode_t    mode_ff,     nxt_mode;
   dmtc_pkg::dmtc_mode_t    target_ff,   nxt_target;
   logic [15:0]             cyc_ff,      nxt_cyc;
   logic [15:0]             scnt_ff,     nxt_scnt;
   logic [15:0]             wait_ff,     nxt_wait;
   logic                    exc_ff,      nxt_exc;
   logic                    done_ff,     nxt_done;
   dmtc_pkg::dmtc_evt_t     evt;

   logic                    state_tick;
   logic                    match;
   dmtc_pkg::dmtc_mode_t    match_mode;

   // state enable: one pulse per cpu state at the clock now in use
   assign state_tick = (cyc_ff == state_period(mode_ff) - 16'h0_001);

   // =====================================================
   // transfer request decode
   // only the four documented direct paths are decoded; anything else is flagged
   always_comb begin
      match      = 1'b0;
      match_mode = mode_ff;
      if (ctl_two_ff.direct_transfer_on && !ctl_one_ff.low_speed_on) begin
         case (mode_ff)
            dmtc_pkg::DMTC_HS: begin
               if (!ctl_one_ff.standby_select && ctl_two_ff.medium_speed_on) begin
                  match      = 1'b1;
                  match_mode = dmtc_pkg::DMTC_MS;
               end
            end
            dmtc_pkg::DMTC_MS: begin
               if (!ctl_one_ff.standby_select && !ctl_two_ff.medium_speed_on) begin
                  match      = 1'b1;
                  match_mode = dmtc_pkg::DMTC_HS;
               end
            end
            dmtc_pkg::DMTC_SUB: begin
               if (ctl_one_ff.standby_select && twcs_ff) begin
                  match      = 1'b1;
                  match_mode = ctl_two_ff.medium_speed_on ? dmtc_pkg::DMTC_MS
                                                          : dmtc_pkg::DMTC_HS;
               end
            end
            default: begin
               match = 1'b0;
            end
         endcase
      end
   end

   // =====================================================
   // sequencer next state
   always_comb begin
      nxt_state  = state_ff;
      nxt_mode   = mode_ff;
      nxt_target = target_ff;
      nxt_scnt   = scnt_ff;
      nxt_wait   = wait_ff;
      nxt_exc    = 1'b0;
      nxt_done   = 1'b0;
      nxt_cyc    = state_tick ? 16'h0_000 : cyc_ff + 16'h0_001;
      evt        = '0;
      case (state_ff)
         dmtc_pkg::ST_RUN: begin
            if (sleep_exec) begin
               nxt_cyc  = 16'h0_000;
               nxt_scnt = 16'h0_000;
               if (match && ctl_two_ff.dt_int_en && !cpu_int_mask) begin
                  nxt_state  = dmtc_pkg::ST_XFER;
                  nxt_target = match_mode;
                  nxt_wait   = wait_states(ctl_one_ff.wait_sel);
               end else if (match) begin
                  // interrupt cannot be taken, so fall into sleep or watch
                  nxt_state    = dmtc_pkg::ST_LOWPWR;
                  evt.lowpower = 1'b1;
               end else begin
                  evt.unsupported = 1'b1;
               end
            end
         end
         dmtc_pkg::ST_XFER: begin
            // sleep and internal states run on the old clock
            if (state_tick) begin
               nxt_scnt = scnt_ff + 16'h0_001;
               if (scnt_ff == dmtc_pkg::SLEEP_STATES + dmtc_pkg::INTERNAL_STATES - 16'h0_001) begin
                  nxt_mode = target_ff;
                  nxt_scnt = 16'h0_000;
                  if (mode_ff == dmtc_pkg::DMTC_SUB) begin
                     nxt_state = dmtc_pkg::ST_WAIT;
                  end else begin
                     nxt_state = dmtc_pkg::ST_EXC;
                     nxt_exc   = 1'b1;
                  end
               end
            end
         end
         dmtc_pkg::ST_WAIT: begin
            // oscillator settle, counted in states of the new clock
            if (state_tick) begin
               nxt_scnt = scnt_ff + 16'h0_001;
               if (scnt_ff == wait_ff - 16'h0_001) begin
                  nxt_scnt  = 16'h0_000;
                  nxt_state = dmtc_pkg::ST_EXC;
                  nxt_exc   = 1'b1;
               end
            end
         end
         dmtc_pkg::ST_EXC: begin
            if (state_tick) begin
               nxt_scnt = scnt_ff + 16'h0_001;
               if (scnt_ff == dmtc_pkg::EXC_STATES - 16'h0_001) begin
                  nxt_scnt  = 16'h0_000;
                  nxt_state = dmtc_pkg::ST_RUN;
                  nxt_done  = 1'b1;
                  evt.done  = 1'b1;
               end
            end
         end
         dmtc_pkg::ST_LOWPWR: begin
            // stays put until a wakeup; low-speed set at wakeup resumes on the subclock, as out of watch
            if (wake_req) begin
               nxt_state = dmtc_pkg::ST_RUN;
               nxt_cyc   = 16'h0_000;
               if (ctl_one_ff.low_speed_on) begin
                  nxt_mode = dmtc_pkg::DMTC_SUB; // only way into subactive, so its exits are reachable
               end
            end
         end
         default: begin
            nxt_state = dmtc_pkg::ST_RUN;
         end
      endcase
   end

   // sequencer registers; reset lands in medium-speed like a pin reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff  <= dmtc_pkg::ST_RUN;
         mode_ff   <= dmtc_pkg::DMTC_MS;
         target_ff <= dmtc_pkg::DMTC_MS;
         cyc_ff    <= 16'h0_000;
         scnt_ff   <= 16'h0_000;
         wait_ff   <= 16'h0_000;
         exc_ff    <= 1'b0;
         done_ff   <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         mode_ff   <= nxt_mode;
         target_ff <= nxt_target;
         cyc_ff    <= nxt_cyc;
         scnt_ff   <= nxt_scnt;
         wait_ff   <= nxt_wait;
         exc_ff    <= nxt_exc;
         done_ff   <= nxt_done;
      end
   end

   // =====================================================
   // register port and interrupt status
   // control bits stay writable mid-transfer; the sequencer latched what it needs
   always_comb begin
      nxt_ctl_one  = ctl_one_ff;
      nxt_ctl_two  = ctl_two_ff;
      nxt_twcs     = twcs_ff;
      nxt_int_mask = int_mask_ff;
      nxt_int_stat = int_stat_ff;
      nxt_rd_data  = 8'h0_0;
      if (wr_en) begin
         case (addr)
            dmtc_pkg::ADDR_CTL_ONE:  nxt_ctl_one  = wr_data[4:0];
            dmtc_pkg::ADDR_CTL_TWO:  nxt_ctl_two  = wr_data[2:0];
            dmtc_pkg::ADDR_TIMER_A:  nxt_twcs     = wr_data[dmtc_pkg::TWCS_BIT];
            dmtc_pkg::ADDR_INT_MASK: nxt_int_mask = wr_data[2:0];
            dmtc_pkg::ADDR_INT_STAT: nxt_int_stat = int_stat_ff & ~wr_data[2:0];
            default:                 nxt_ctl_one  = ctl_one_ff;
         endcase
      end
      // set beats a simultaneous clear
      nxt_int_stat = nxt_int_stat | evt;
      if (rd_en) begin
         case (addr)
            dmtc_pkg::ADDR_CTL_ONE:  nxt_rd_data = {3'h0, ctl_one_ff};
            dmtc_pkg::ADDR_CTL_TWO:  nxt_rd_data = {5'h0_0, ctl_two_ff};
            dmtc_pkg::ADDR_TIMER_A:  nxt_rd_data = {4'h0, twcs_ff, 3'h0};
            dmtc_pkg::ADDR_STATUS:   nxt_rd_data = {1'b0, state_ff, target_ff, mode_ff};
            dmtc_pkg::ADDR_INT_STAT: nxt_rd_data = {5'h0_0, int_stat_ff};
            dmtc_pkg::ADDR_INT_MASK: nxt_rd_data = {5'h0_0, int_mask_ff};
            default:                 nxt_rd_data = 8'h0_0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctl_one_ff  <= dmtc_pkg::CTL_ONE_RST[4:0];
         ctl_two_ff  <= dmtc_pkg::CTL_TWO_RST[2:0];
         twcs_ff     <= 1'b0;
         int_stat_ff <= '0;
         int_mask_ff <= '0;
         rd_data_ff  <= 8'h0_0;
      end else begin
         ctl_one_ff  <= nxt_ctl_one;
         ctl_two_ff  <= nxt_ctl_two;
         twcs_ff     <= nxt_twcs;
         int_stat_ff <= nxt_int_stat;
         int_mask_ff <= nxt_int_mask;
         rd_data_ff  <= nxt_rd_data;
      end
   end

   // =====================================================
   // outputs
   assign rd_data     = rd_data_ff;
   assign cpu_clk_sel = mode_ff;   // switches on a state tick, or at the wakeup that resumes on the subclock
   assign cpu_hold    = (state_ff == dmtc_pkg::ST_XFER) || (state_ff == dmtc_pkg::ST_WAIT);
   assign exc_start   = exc_ff;
   assign xfer_done   = done_ff;
   assign lowpower_on = (state_ff == dmtc_pkg::ST_LOWPWR);
   assign irq         = |(int_stat_ff & int_mask_ff);

endmodule

// *** common/dmtc_pkg.sv ***
// constants, types and register layout of the direct mode transition controller
// assumes one 50 MHz clock standing in for the oscillator; slower clocks are enables
package dmtc_pkg;
   // =====================================================
   // modes and sequencer states
   typedef enum logic [1:0] {
      DMTC_HS  = 2'b00,
      DMTC_MS  = 2'b01,
      DMTC_SUB = 2'b10
   } dmtc_mode_t;

   typedef enum logic [2:0] {
      ST_RUN    = 3'b000,
      ST_XFER   = 3'b001,
      ST_WAIT   = 3'b010,
      ST_EXC    = 3'b011,
      ST_LOWPWR = 3'b100
   } dmtc_state_t;

   // =====================================================
   // register layout
   typedef struct packed {
      logic [2:0] wait_sel;
      logic       low_speed_on;
      logic       standby_select;
   } dmtc_ctl_one_t;

   typedef struct packed {
      logic dt_int_en;
      logic direct_transfer_on;
      logic medium_speed_on;
   } dmtc_ctl_two_t;

   typedef struct packed {
      logic unsupported;
      logic lowpower;
      logic done;
   } dmtc_evt_t;

   localparam logic [7:0] ADDR_CTL_ONE  = 8'h0_0;
   localparam logic [7:0] ADDR_CTL_TWO  = 8'h0_4;
   localparam logic [7:0] ADDR_TIMER_A  = 8'h0_8;
   localparam logic [7:0] ADDR_STATUS   = 8'h0_C;
   localparam logic [7:0] ADDR_INT_STAT = 8'h1_0;
   localparam logic [7:0] ADDR_INT_MASK = 8'h1_4;
   localparam int         TWCS_BIT      = 3;
   localparam logic [7:0] CTL_ONE_RST   = 8'h0_0;
   localparam logic [7:0] CTL_TWO_RST   = 8'h0_0;

   // =====================================================
   // timing, in states and in oscillator cycles per state
   localparam logic [15:0] SLEEP_STATES    = 16'h0_002;
   localparam logic [15:0] INTERNAL_STATES = 16'h0_001;
   localparam logic [15:0] EXC_STATES      = 16'h0_00E;
   localparam logic [15:0] HS_DIV          = 16'h0_002;
   localparam logic [15:0] MS_DIV          = 16'h0_010;
   localparam logic [15:0] SUB_TW_MULT     = 16'h0_008;
   // short wait settings for the selector values other than zero
   localparam logic [15:0] WAIT_SEL1 = 16'h0_010;
   localparam logic [15:0] WAIT_SEL2 = 16'h0_020;
   localparam logic [15:0] WAIT_SEL3 = 16'h0_040;
   localparam logic [15:0] WAIT_SEL4 = 16'h0_080;
   localparam logic [15:0] WAIT_SEL5 = 16'h0_100;
   localparam logic [15:0] WAIT_SEL6 = 16'h0_200;
   localparam logic [15:0] WAIT_SEL7 = 16'h0_400;
endpackage

// *** testbench/dmtc_chk.sv ***
// port-level checks of the direct mode transition sequencer
// assumes binding into dmtc_top; sees its ports only
module dmtc_chk (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic       wr_en,
   input wire logic       sleep_exec,
   input wire logic       cpu_int_mask,
   input wire logic [1:0] cpu_clk_sel,
   input wire logic       cpu_hold,
   input wire logic       exc_start,
   input wire logic       xfer_done,
   input wire logic       lowpower_on
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // =========================================
   // shadow of control bits, registers are not visible here
   logic [1:0] c1_ff;
   logic [2:0] c2_ff;
   logic       exc_ff;
   logic       tw_ff;
   logic       go;
   logic       sub_go;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         c1_ff <= 2'h0;
         c2_ff <= 3'h0;
         exc_ff <= 1'b0;
         tw_ff <= 1'b0;
      end else begin
         if (wr_en && addr == dmtc_pkg::ADDR_TIMER_A) tw_ff <= wr_data[dmtc_pkg::TWCS_BIT];
         if (wr_en && addr == dmtc_pkg::ADDR_CTL_ONE) c1_ff <= wr_data[1:0];
         if (wr_en && addr == dmtc_pkg::ADDR_CTL_TWO) c2_ff <= wr_data[2:0];
         exc_ff <= exc_start | (exc_ff & ~xfer_done);
      end
   end
   // a sleep the sequencer must take, low-speed and standby off
   assign go = sleep_exec && !cpu_hold && !lowpower_on && !exc_start && !(exc_ff && !xfer_done)
               && c1_ff == 2'h0 && !cpu_int_mask;
   // a subactive exit the sequencer must take: standby set, low-speed off, watch clock selected
   assign sub_go = sleep_exec && !cpu_hold && !lowpower_on && !exc_start && !(exc_ff && !xfer_done)
                   && c1_ff == 2'b01 && tw_ff && !cpu_int_mask && cpu_clk_sel == 2'b10;
   // =========================================
   // assertions
   AST_HS_TO_MS: assert property (go && cpu_clk_sel == 2'b00 && c2_ff == 3'b111
      |=> cpu_hold [*6] ##1 exc_start && !cpu_hold && cpu_clk_sel == 2'b01) else $error("hs to ms wrong");
   AST_MS_TO_HS: assert property (go && cpu_clk_sel == 2'b01 && c2_ff == 3'b110
      |=> cpu_hold ##48 exc_start && cpu_clk_sel == 2'b00) else $error("ms to hs wrong");
   // three subclock states of 32 clocks each, default watch period assumed
   AST_SUB_TO_HS: assert property (sub_go && c2_ff == 3'b110
      |=> ##95 (cpu_hold && cpu_clk_sel == 2'b10) ##1 (cpu_hold && cpu_clk_sel == 2'b00)) else $error("sub to hs wrong");
   AST_SUB_TO_MS: assert property (sub_go && c2_ff == 3'b111
      |=> ##95 (cpu_hold && cpu_clk_sel == 2'b10) ##1 (cpu_hold && cpu_clk_sel == 2'b01)) else $error("sub to ms wrong");
   AST_EXC_MS: assert property (exc_start && cpu_clk_sel == 2'b01 |-> ##224 xfer_done)
      else $error("medium exception length wrong");
   AST_EXC_HS: assert property (exc_start && cpu_clk_sel == 2'b00 |-> ##28 xfer_done)
      else $error("high exception length wrong");
   AST_SEL_EDGE: assert property ($changed(cpu_clk_sel) && $past(cpu_clk_sel) != 2'b10 && cpu_clk_sel != 2'b10
      |-> exc_start) else $error("clock switched off boundary");
   // leaving the subclock switches into the still-held wait phase
   AST_SUB_SEL: assert property ($changed(cpu_clk_sel) && $past(cpu_clk_sel) == 2'b10
      |-> cpu_hold && $past(cpu_hold)) else $error("subclock left outside hold");
   AST_SUB_ENTRY: assert property ($changed(cpu_clk_sel) && cpu_clk_sel == 2'b10
      |-> $past(lowpower_on) && !lowpower_on) else $error("subclock entered without wakeup");
   AST_HOLD_END: assert property ($fell(cpu_hold) |-> exc_start)
      else $error("hold ended without exception");
   AST_FALLBACK: assert property (go && cpu_clk_sel == 2'b01 && c2_ff == 3'b010
      |=> lowpower_on && !cpu_hold) else $error("no fallback to low power");
   AST_NO_MATCH: assert property (go && !c2_ff[1]
      |=> !cpu_hold && !lowpower_on && $stable(cpu_clk_sel)) else $error("transfer without enable");
   // main scenarios
   cover property (exc_start && cpu_clk_sel == 2'b01);
   cover property (exc_start && cpu_clk_sel == 2'b00);
   cover property ($rose(lowpower_on));
   cover property ($past(cpu_clk_sel) == 2'b10 && cpu_clk_sel != 2'b10);
endmodule
bind dmtc_top dmtc_chk dmtc_chk_inst (.*);

// *** testbench/tb_dmtc_top.sv ***
// self-checking bench of the direct mode transition sequencer
// assumes package first and the checker bound in
module tb_dmtc_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic [7:0] addr = 8'h0_0;
   logic [7:0] wr_data = 8'h0_0;
   logic       wr_en = 1'b0;
   logic       rd_en = 1'b0;
   logic       sleep_exec = 1'b0;
   logic       cpu_int_mask = 1'b0;
   logic       wake_req = 1'b0;
   logic [7:0] rd_data;
   logic [1:0] cpu_clk_sel;
   logic       cpu_hold;
   logic       exc_start;
   logic       xfer_done;
   logic       lowpower_on;
   logic       irq;
   int         n_fail = 0;
   int         num_checks = 0;
   int         cyc = 0;
   always #10 clk = ~clk;
   // short long-wait count keeps runs small
   dmtc_top #(.WAIT_LONG_STATES(16'h0_004), .TW_CLKS(16'h0_004)) dmtc_top_inst (
      .clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .rd_data(rd_data), .sleep_exec(sleep_exec), .cpu_int_mask(cpu_int_mask), .wake_req(wake_req),
      .cpu_clk_sel(cpu_clk_sel), .cpu_hold(cpu_hold), .exc_start(exc_start), .xfer_done(xfer_done),
      .lowpower_on(lowpower_on), .irq(irq));
   // =========================================
   // helpers
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard, whole run is about nine hundred forty cycles, ceiling near three times that
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         end_sim();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(what, 16'(rd_data), 16'(exp));
   endtask
   // one-cycle sleep or wakeup strobe, then three quiet cycles
   task automatic pulse(input logic wake);
      @(posedge clk);
      if (wake) wake_req <= 1'b1;
      else sleep_exec <= 1'b1;
      @(posedge clk);
      wake_req <= 1'b0;
      sleep_exec <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   // sleep, then count edges to exception start and to completion
   task automatic sleep_go(input int e_exc, input int e_done, input logic [1:0] sel);
      int k;
      k = 0;
      @(posedge clk);
      sleep_exec <= 1'b1;
      @(posedge clk);
      sleep_exec <= 1'b0;
      #1;
      while (exc_start !== 1'b1 && k < 400) begin
         @(posedge clk);
         #1 k++;
      end
      chk("exc_at", 16'(k), 16'(e_exc));
      chk("sel", 16'(cpu_clk_sel), 16'(sel));
      while (xfer_done !== 1'b1 && k < 400) begin
         @(posedge clk);
         #1 k++;
      end
      chk("done_at", 16'(k), 16'(e_done));
   endtask
   // =========================================
   // scenarios
   task automatic t_regs();
      #1 chk("rst_sel", 16'(cpu_clk_sel), 16'h0_001);
      rd(dmtc_pkg::ADDR_CTL_TWO, dmtc_pkg::CTL_TWO_RST, "ctl_two");
      wr(dmtc_pkg::ADDR_INT_MASK, 8'hF_F);
      rd(dmtc_pkg::ADDR_INT_MASK, 8'h0_7, "mask");
      wr(8'h3_0, 8'hA_5);
      rd(8'h3_0, 8'h0_0, "unmapped");
   endtask
   // sleep without transfer enable only flags the event
   task automatic t_unsup();
      wr(dmtc_pkg::ADDR_INT_MASK, 8'h0_4);
      pulse(1'b0);
      chk("hold", 16'(cpu_hold), 16'h0_000);
      chk("irq", 16'(irq), 16'h0_001);
      wr(dmtc_pkg::ADDR_INT_STAT, 8'h0_4);
      #1 chk("irq_clr", 16'(irq), 16'h0_000);
   endtask
   // blocked transfer interrupt falls back to low power
   task automatic t_fallback();
      for (int i = 0; i < 2; i++) begin
         wr(dmtc_pkg::ADDR_CTL_TWO, (i == 1) ? 8'h0_6 : 8'h0_2);
         cpu_int_mask <= i[0];
         pulse(1'b0);
         chk("lowpower", 16'(lowpower_on), 16'h0_001);
         chk("lp_sel", 16'(cpu_clk_sel), 16'h0_001);
         rd(dmtc_pkg::ADDR_INT_STAT, 8'h0_2, "lp_stat");
         wr(dmtc_pkg::ADDR_INT_STAT, 8'h0_2);
         pulse(1'b1);
         chk("woke", 16'(lowpower_on), 16'h0_000);
      end
      cpu_int_mask <= 1'b0;
   endtask
   task automatic t_direct();
      wr(dmtc_pkg::ADDR_INT_MASK, 8'h0_1);
      wr(dmtc_pkg::ADDR_CTL_TWO, 8'h0_6);
      sleep_go(48, 76, 2'b00);
      #1 chk("irq_done", 16'(irq), 16'h0_001);
      wr(dmtc_pkg::ADDR_INT_STAT, 8'h0_1);
      wr(dmtc_pkg::ADDR_CTL_TWO, 8'h0_7);
      sleep_go(6, 230, 2'b01);
      rd(dmtc_pkg::ADDR_INT_STAT, 8'h0_1, "done_stat");
   endtask
   // park in low power, wake with low-speed set, then leave subactive to high and to medium speed
   task automatic t_sub();
      for (int i = 0; i < 2; i++) begin
         wr(dmtc_pkg::ADDR_CTL_ONE, 8'h0_0);
         wr(dmtc_pkg::ADDR_CTL_TWO, (i == 1) ? 8'h0_3 : 8'h0_2);
         pulse(1'b0);
         wr(dmtc_pkg::ADDR_CTL_ONE, 8'h0_2);
         pulse(1'b1);
         chk("sub_sel", 16'(cpu_clk_sel), 16'h0_002);
         rd(dmtc_pkg::ADDR_STATUS, (i == 1) ? 8'h0_2 : 8'h0_6, "status");
         wr(dmtc_pkg::ADDR_CTL_ONE, 8'h0_1);
         wr(dmtc_pkg::ADDR_TIMER_A, 8'h0_8);
         wr(dmtc_pkg::ADDR_CTL_TWO, (i == 1) ? 8'h0_7 : 8'h0_6);
         if (i == 1) sleep_go(160, 384, 2'b01);
         else sleep_go(104, 132, 2'b00);
      end
   endtask
   // reset for two cycles, then the scenarios in turn
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      t_unsup();
      t_fallback();
      t_direct();
      t_sub();
      end_sim();
   end
endmodule
